// ===== inc/launch_pkg.sv
// Constants and types shared by the standalone launch control block
`default_nettype none
package launch_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;      // System clock rate
  localparam int unsigned LONG_HOLD_MS    = 2000;            // Standalone entry hold, 2 seconds
  localparam int unsigned SHORT_HOLD_US   = 1000;            // Job launch hold, 1 ms
  localparam int unsigned BLINK_MS        = 250;             // Blink half period
  localparam int unsigned DEBOUNCE_US     = 100;             // Button debounce time
  localparam int unsigned LONG_HOLD_CYC   = (CLK_HZ / 1000) * LONG_HOLD_MS;
  localparam int unsigned SHORT_HOLD_CYC  = ((CLK_HZ / 1000) * SHORT_HOLD_US + 999) / 1000;
  localparam int unsigned BLINK_CYC       = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned DEBOUNCE_CYC    = ((CLK_HZ / 1000) * DEBOUNCE_US + 999) / 1000;
  localparam int unsigned CNT_W           = 26;              // Wide enough for the longest count
  localparam int unsigned SEL_W           = 6;               // Job select lines
  localparam int unsigned JOB_MAX         = 255;             // Largest job count stored
  localparam logic [7:0]  JOB_RESET       = 8'h00;           // Job latched at reset
  typedef enum logic [1:0] {MODE_IDLE, MODE_STANDALONE, MODE_HOST} mode_type;
  typedef enum logic [1:0] {RUN_READY, RUN_BUSY} run_type;
endpackage : launch_pkg
`default_nettype wire

// ===== logic/launch_ctrl.sv
// Standalone mode entry, job launch and status outputs of the programmer
`default_nettype none
module launch_ctrl
  import launch_pkg::*;
#(
  parameter int unsigned LONG_CYC  = LONG_HOLD_CYC,       // Standalone entry hold in cycles
  parameter int unsigned BLINK_HALF = BLINK_CYC           // Blink half period in cycles
) (
  input  wire logic             clk,            // 20 MHz system clock
  input  wire logic             reset_n,        // Async reset, active low
  input  wire logic             standalone_strap, // Strap pin, high means standalone
  input  wire logic             start_n,        // Start pin, active low
  input  wire logic             button_n,       // Start pushbutton, active low
  input  wire logic [SEL_W-1:0] job_sel,        // Job select pins, pulled low off-board
  input  wire logic             host_request,   // Host asks for computer control
  input  wire logic             job_done,       // Job engine finished, one-cycle pulse
  input  wire logic             job_ok,         // Result of finished job, high is pass
  output logic                  job_launch,     // One-cycle launch pulse to job engine
  output logic [7:0]            job_index,      // Job number held while busy
  output logic                  standalone,     // Standalone mode active
  output logic                  pass_n,         // Pass line, active low
  output logic                  busy_n,         // Busy line, active low
  output logic                  fail_n,         // Fail line, active low
  output logic                  led_green,      // Green lamp, high lit
  output logic                  led_yellow,     // Yellow lamp, high lit
  output logic                  led_red         // Red lamp, high lit
);
  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0]       strap_s_q;                  // Strap sync chain
  logic [1:0]       start_s_q;                  // Start pin sync chain
  logic [1:0]       btn_s_q;                    // Button sync chain
  logic [SEL_W-1:0] sel_a_q;                    // Select first stage
  logic [SEL_W-1:0] sel_b_q;                    // Select second stage

  // Two stages before any logic looks at a pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_s_q <= 2'h0;
      start_s_q <= 2'h3;
      btn_s_q   <= 2'h3;
      sel_a_q   <= 6'h00;
      sel_b_q   <= 6'h00;
    end else begin
      strap_s_q <= {strap_s_q[0], standalone_strap};
      start_s_q <= {start_s_q[0], start_n};
      btn_s_q   <= {btn_s_q[0], button_n};
      sel_a_q   <= job_sel;
      sel_b_q   <= sel_a_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Button debounce; contact bounce would fake a release mid-hold
  logic [CNT_W-1:0] deb_q;                      // Stable-level counter
  logic             btn_q;                      // Debounced level, high pressed

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deb_q <= '0;
      btn_q <= 1'b0;
    end else if ((!btn_s_q[1]) == btn_q) begin
      deb_q <= '0;
    end else if (deb_q == CNT_W'(DEBOUNCE_CYC - 1)) begin
      deb_q <= '0;
      btn_q <= !btn_s_q[1];
    end else begin
      deb_q <= deb_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hold timers for the start pin and the button
  logic [CNT_W-1:0] pin_cnt_q;                  // Cycles start pin held low
  logic [CNT_W-1:0] btn_cnt_q;                  // Cycles button held
  logic             pin_low;                    // Synced start pin asserted
  logic             pin_long;                   // Pin hold reached two seconds
  logic             pin_short;                  // Pin hold reached 1 ms
  logic             btn_long;                   // Button hold reached two seconds
  logic             pin_low_q;                  // Pin level last cycle
  logic             btn_prev_q;                 // Button level last cycle

  assign pin_low   = !start_s_q[1];
  assign pin_long  = pin_cnt_q >= CNT_W'(LONG_CYC);
  assign pin_short = pin_cnt_q >= CNT_W'(SHORT_HOLD_CYC);
  assign btn_long  = btn_cnt_q >= CNT_W'(LONG_CYC);

  // Counters saturate so a held line cannot wrap around
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_cnt_q <= '0;
      btn_cnt_q <= '0;
    end else begin
      // Stop at all ones, not at the entry hold, so the 1 ms mark stays reachable
      if (!pin_low)
        pin_cnt_q <= '0;
      else if (pin_cnt_q != '1)
        pin_cnt_q <= pin_cnt_q + 1'b1;
      if (!btn_q)
        btn_cnt_q <= '0;
      else if (btn_cnt_q != '1)
        btn_cnt_q <= btn_cnt_q + 1'b1;
    end
  end

  // Edge history for release detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_low_q  <= 1'b0;
      btn_prev_q <= 1'b0;
    end else begin
      pin_low_q  <= pin_low;
      btn_prev_q <= btn_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode control
  mode_type mode_q;                             // Operating mode
  run_type  run_q;                              // Job engine state
  logic [1:0] strap_age_q;                      // Edges since reset, strap checked at 2
  logic     entry_hold_q;                       // Press that entered standalone still held
  logic     pin_fire;                           // Pin released after a 1 ms hold
  logic     btn_fire;                           // Button released after a press

  // A launch fires on release, so the press that enters the mode is not also a launch
  // On the release cycle the counter still holds the full hold length
  assign pin_fire = pin_low_q && !pin_low && pin_short && !entry_hold_q;
  assign btn_fire = btn_prev_q && !btn_q && !entry_hold_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q       <= MODE_IDLE;
      strap_age_q  <= 2'h0;
      entry_hold_q <= 1'b0;
    end else begin
      // The strap reaches the second sync stage at the second edge and is checked at the third
      if (strap_age_q != 2'h3)
        strap_age_q <= strap_age_q + 2'h1;
      if (!pin_low && !btn_q)
        entry_hold_q <= 1'b0;
      if (mode_q == MODE_STANDALONE) begin
        if (host_request && run_q == RUN_READY)
          mode_q <= MODE_HOST;
      end else if (strap_age_q == 2'h2 && strap_s_q[1]) begin
        mode_q <= MODE_STANDALONE;
      end else if (pin_long || btn_long) begin
        mode_q       <= MODE_STANDALONE;
        entry_hold_q <= 1'b1;
      end else if (mode_q == MODE_IDLE && host_request) begin
        mode_q <= MODE_HOST;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Job launch and result tracking
  logic    pass_q;                              // Last job passed
  logic    fail_q;                              // Last job failed

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q      <= RUN_READY;
      job_launch <= 1'b0;
      job_index  <= JOB_RESET;
      pass_q     <= 1'b0;
      fail_q     <= 1'b0;
    end else begin
      job_launch <= 1'b0;
      unique case (run_q)
        RUN_READY: begin
          if (mode_q == MODE_STANDALONE && (pin_fire || btn_fire)) begin
            run_q      <= RUN_BUSY;
            job_launch <= 1'b1;
            job_index  <= {2'h0, sel_b_q};
            pass_q     <= 1'b0;
            fail_q     <= 1'b0;
          end
        end
        RUN_BUSY: begin
          if (job_done) begin
            run_q  <= RUN_READY;
            pass_q <= job_ok;
            fail_q <= !job_ok;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Blink generator
  logic [CNT_W-1:0] blink_cnt_q;                // Half-period counter
  logic             blink_q;                    // Blink phase

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == CNT_W'(BLINK_HALF - 1)) begin
      blink_cnt_q <= '0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers; blinking stands idle, results take over once a job has run
  logic sa;                                     // Standalone active
  logic busy;                                   // Job running
  logic idle_blink;                             // Idle standalone with no result
  assign sa         = mode_q == MODE_STANDALONE;
  assign busy       = run_q == RUN_BUSY;
  assign idle_blink = sa && !busy && !pass_q && !fail_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      standalone <= 1'b0;
      pass_n     <= 1'b1;
      busy_n     <= 1'b1;
      fail_n     <= 1'b1;
      led_green  <= 1'b0;
      led_yellow <= 1'b0;
      led_red    <= 1'b0;
    end else begin
      standalone <= sa;
      pass_n     <= !(sa && pass_q && !busy);
      busy_n     <= !(sa && busy);
      fail_n     <= !(sa && fail_q && !busy);
      led_green  <= (sa && pass_q && !busy) || (idle_blink && blink_q);
      led_yellow <= sa && busy;
      led_red    <= (sa && fail_q && !busy) || (idle_blink && blink_q);
    end
  end
  // Index is eight bits wide, room for every stored job
endmodule : launch_ctrl
`default_nettype wire

// ===== dv/launch_ctrl_sva.sv
// Port assertions for the launch control block
`default_nettype none
module launch_ctrl_sva (
  input wire logic       clk,        // System clock
  input wire logic       reset_n,    // Async reset, low
  input wire logic       job_done,   // Job end pulse
  input wire logic       job_ok,     // Pass result
  input wire logic       job_launch, // Launch pulse
  input wire logic [7:0] job_index,  // Latched job
  input wire logic       standalone, // Mode flag
  input wire logic       pass_n,     // Pass, low
  input wire logic       busy_n,     // Busy, low
  input wire logic       fail_n,     // Fail, low
  input wire logic       led_yellow  // Busy lamp
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so one default clocking
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  pulse_one_a: assert property (job_launch |=> !job_launch)
    else $error("launch pulse wider than one cycle");
  launch_gate_a: assert property (job_launch |-> standalone && busy_n)
    else $error("launch outside standalone or while busy");
  busy_start_a: assert property (job_launch |=> !busy_n)
    else $error("busy not low after launch");
  // Held past the done pulse by one cycle of latency
  busy_hold_a: assert property (!busy_n && !job_done && !$past(job_done) |=> !busy_n)
    else $error("busy dropped without job end");
  busy_end_a: assert property (!busy_n && job_done |-> ##[1:2] busy_n)
    else $error("busy stuck after job end");
  pass_show_a: assert property (!busy_n && job_done && job_ok |-> ##[1:2] !pass_n && fail_n)
    else $error("pass result not shown");
  fail_show_a: assert property (!busy_n && job_done && !job_ok |-> ##[1:2] !fail_n && pass_n)
    else $error("fail result not shown");
  yellow_lamp_a: assert property (led_yellow == !busy_n)
    else $error("yellow lamp differs from busy");
  status_gate_a: assert property (!standalone |-> pass_n && busy_n && fail_n)
    else $error("status line active outside standalone");
  index_hold_a: assert property (!job_launch |-> $stable(job_index))
    else $error("job index moved without launch");
endmodule // launch_ctrl_sva
`default_nettype wire

// ===== dv/ate_model.sv
// Test equipment model driving start and job select pins
`default_nettype none
module ate_model
  import launch_pkg::*;
(
  input  wire logic             clk,     // Bench clock
  output var  logic             start_n, // Start pin, low active
  output var  logic [SEL_W-1:0] job_sel  // Job select pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle pins: start released high, select pulled down
  initial begin
    start_n = 1'b1;
    job_sel = '0;
  end
  // Hold start low cyc cycles with a job chosen
  task automatic hold_start(input int cyc, input logic [SEL_W-1:0] s);
    @(posedge clk) #2;
    job_sel = s;
    start_n = 1'b0;
    repeat (cyc) @(posedge clk);
    #2 start_n = 1'b1;
    // Keep select past the sync delay, then let pull-downs win
    repeat (6) @(posedge clk);
    #2 job_sel = '0;
  endtask
endmodule // ate_model
`default_nettype wire

// ===== dv/launch_ctrl_test.sv
// Self-checking bench for the launch control block
`default_nettype none
module launch_ctrl_test
  import launch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;                  // 20 MHz clock
  logic reset_n, standalone_strap;   // Reset and strap
  logic button_n, host_request;      // Panel and host inputs
  logic job_done, job_ok;            // Job engine stand-in
  wire logic start_n;                // From test equipment
  wire logic [SEL_W-1:0] job_sel;    // From test equipment
  logic job_launch, standalone;      // Launch and mode
  logic [7:0] job_index;             // Latched job
  logic pass_n, busy_n, fail_n;      // Status lines
  logic led_green, led_yellow, led_red; // Lamps
  int mismatches, samples_checked, cyc, tg, tr; // Counters
  logic [31:0] rng;                  // Random state
  logic [SEL_W-1:0] s;               // Chosen job
  logic g, r;                        // Previous lamp levels
  logic [7:0] exp_q[$];              // Expected job per launch
  launch_ctrl #(.LONG_CYC(200), .BLINK_HALF(8)) launch_ctrl_i (.clk, .reset_n, .standalone_strap,
    .start_n, .button_n, .job_sel, .host_request, .job_done, .job_ok, .job_launch, .job_index,
    .standalone, .pass_n, .busy_n, .fail_n, .led_green, .led_yellow, .led_red);
  ate_model ate_i (.clk, .start_n, .job_sel);
  always #25 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait, long enough for the button debounce
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 3000 && busy_n !== v; n++) @(posedge clk);
    #2;
  endtask
  task automatic finish_job(input logic ok);
    @(posedge clk) #2;
    job_done = 1'b1;
    job_ok = ok;
    @(posedge clk) #2;
    job_done = 1'b0;
    repeat (3) @(posedge clk);
    #2;
  endtask
  task automatic pulse_reset(input logic strap);
    @(posedge clk) #2;
    reset_n = 1'b0;
    standalone_strap = strap; // Strap held through power-up
    repeat (4) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (10) @(posedge clk);
    #2;
  endtask
  // Each launch is compared with the oldest queued job, mid-cycle while the pulse stands
  // An unexpected launch meets 8'hFF, never a legal index since the top bits are zero
  always @(negedge clk) begin
    if (job_launch === 1'b1) begin
      check(job_index, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hFF);
    end
  end
  // Hang guard sized from the two 1 ms launches
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    {reset_n, standalone_strap, button_n, job_done, job_ok, host_request} = 6'b001000;
    rng = 32'h3A3FFEFE;
    pulse_reset(1'b0);
    check(8'({standalone, pass_n, busy_n, fail_n}), 8'h07);
    ate_i.hold_start(210, 6'h00);
    check(8'({standalone, busy_n}), 8'h03);
    tg = 0;
    tr = 0;
    repeat (40) begin
      g = led_green;
      r = led_red;
      @(posedge clk) #2;
      tg += int'(led_green !== g);
      tr += int'(led_red !== r);
    end
    check(8'(tg > 3 && tr > 3), 8'h01);
    ate_i.hold_start(100, 6'h05);
    check(8'(busy_n), 8'h01);
    $display("entry test done");
    for (int i = 0; i < 2; i++) begin
      rng = xs(rng);
      s = (i == 0) ? 6'h21 : rng[5:0];
      exp_q.push_back({2'b00, s});
      ate_i.hold_start(20005, s);
      wait_busy(1'b0);
      check(8'({busy_n, led_yellow}), 8'h01);
      finish_job(i == 0);
      check(job_index, {2'b00, s});
      check(8'({busy_n, pass_n, fail_n}), (i == 0) ? 8'h05 : 8'h06);
      check(8'({led_green, led_red}), (i == 0) ? 8'h02 : 8'h01);
      $display("pin launch test %0d done", i);
    end
    exp_q.push_back(8'h00);
    button_n = 1'b0;
    repeat (2500) @(posedge clk);
    #2 button_n = 1'b1;
    wait_busy(1'b0);
    check(8'(busy_n), 8'h00);
    finish_job(1'b1);
    host_request = 1'b1;
    repeat (5) @(posedge clk);
    #2 host_request = 1'b0;
    check(8'(standalone), 8'h00);
    $display("button launch test done");
    pulse_reset(1'b0);
    button_n = 1'b0;
    repeat (2500) @(posedge clk);
    #2 check(8'(standalone), 8'h01);
    button_n = 1'b1;
    repeat (2200) @(posedge clk);
    #2 check(8'(busy_n), 8'h01);
    pulse_reset(1'b1);
    check(8'(standalone), 8'h01);
    $display("mode entry test done");
    print_verdict();
  end
endmodule // launch_ctrl_test
bind launch_ctrl launch_ctrl_sva launch_ctrl_sva_i (.clk, .reset_n, .job_done, .job_ok, .job_launch,
  .job_index, .standalone, .pass_n, .busy_n, .fail_n, .led_yellow);
`default_nettype wire
